// ==== uts_pkg.sv ====
package uts_pkg;
	// Port count and index width of the multi-PHY slave
	localparam int NPORTS = 32;
	localparam int PORT_INDEX_BITS = $clog2(NPORTS);
	// Bus widths
	localparam int ADDR_W = 5;
	localparam int UWORD_W = 16;
	localparam int DWORD_W = 32;
	// Cell layout on the 16-bit bus, word counter is five bits wide
	localparam logic [4:0] WORD_FIRST = 5'h00;
	localparam logic [4:0] WORD_HEC = 5'h02;
	localparam logic [4:0] WORD_LAST = 5'h19;
	localparam logic [15:0] HEC_DUMMY = 16'h0000;
	// Port map reset values
	localparam logic MAP_EN_RST = 1'b0;
	localparam logic [4:0] MAP_PHY_RST = 5'h00;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_FETCH = 2'b01,
		RX_SEND = 2'b11
	} uts_rx_state_e;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_RECV = 1'b1
	} uts_tx_state_e;
endpackage : uts_pkg

// ==== uts_port_map.sv ====
module uts_port_map (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write port
	input wire logic we,
	input wire logic [uts_pkg::PORT_INDEX_BITS-1:0] wr_port,
	input wire logic [uts_pkg::ADDR_W-1:0] wr_phy,
	input wire logic wr_en,
	// All entries in parallel, straight from the entry registers
	output logic [uts_pkg::NPORTS*uts_pkg::ADDR_W-1:0] map_phy,
	output logic [uts_pkg::NPORTS-1:0] map_en
);
	////////////////////////////////////////////////////////////////////////////////
	// One entry per logical port: bus address it answers to, and enable
	for (genvar p = 0; p < uts_pkg::NPORTS; p++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				map_phy[p*uts_pkg::ADDR_W +: uts_pkg::ADDR_W] <= uts_pkg::MAP_PHY_RST;
				map_en[p] <= uts_pkg::MAP_EN_RST;
			end else if (we && wr_port == uts_pkg::PORT_INDEX_BITS'(p)) begin
				map_phy[p*uts_pkg::ADDR_W +: uts_pkg::ADDR_W] <= wr_phy;
				map_en[p] <= wr_en;
			end
		end
	end
endmodule : uts_port_map

// ==== uts_slave_port.sv ====
// Contract
// R1 - Receive: 32-bit dwords out as 16-bit words
// R2 - Serve up to 32 ports per direction
// R3 - Master polls address, slave answers availability
// R4 - Receive clav equals addressed port FIFO ready
// R5 - Receive cell is twenty-six word transfers
// R6 - Receive third word is dummy HEC
// R7 - Earlier byte sits in upper half
// R8 - Host-written table maps bus to logical ports
// R9 - Receive FIFO readiness tracked per port
// R10 - Transmit: word pairs packed into dwords with port
// R11 - Transmit clav only when FIFO accepts cell
// R12 - Selected port's dwords strobed by data enable
// R13 - Transmit: twenty-six words, third masked as HEC
// R14 - Port count and index width are parameters
// R15 - Master polls ports, keeps status before selecting
// R16 - Clav driven next cycle only for own address
// R17 - Transfer needs last clav asserted; ends word 26
module uts_slave_port (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// Port map configuration
	input wire logic CFG_WE,
	input wire logic [uts_pkg::PORT_INDEX_BITS-1:0] CFG_PORT,
	input wire logic [uts_pkg::ADDR_W-1:0] CFG_PHY,
	input wire logic CFG_EN,
	// Receive direction, bus side
	input wire logic [uts_pkg::ADDR_W-1:0] RX_ADDR,
	input wire logic RX_ENB_N,
	output logic RX_CLAV,
	output logic RX_CLAV_OE,
	output logic [uts_pkg::UWORD_W-1:0] RX_DATA,
	output logic RX_SOC,
	output logic RX_DATA_OE,
	// Receive direction, cell FIFO side
	input wire logic [uts_pkg::NPORTS-1:0] RXF_READY,
	input wire logic [uts_pkg::DWORD_W-1:0] RXF_DATA,
	output logic [uts_pkg::PORT_INDEX_BITS-1:0] RXF_PORT,
	output logic RXF_RD,
	// Transmit direction, bus side
	input wire logic [uts_pkg::ADDR_W-1:0] TX_ADDR,
	input wire logic TX_ENB_N,
	input wire logic [uts_pkg::UWORD_W-1:0] TX_DATA,
	input wire logic TX_SOC,
	output logic TX_CLAV,
	output logic TX_CLAV_OE,
	// Transmit direction, cell FIFO side
	input wire logic [uts_pkg::NPORTS-1:0] TXF_READY,
	output logic [uts_pkg::DWORD_W-1:0] TXF_DATA,
	output logic [uts_pkg::PORT_INDEX_BITS-1:0] TXF_PORT,
	output logic TXF_WE
);
	localparam int PIB = uts_pkg::PORT_INDEX_BITS;
	localparam int AW = uts_pkg::ADDR_W;

	logic [uts_pkg::NPORTS*AW-1:0] map_phy;
	logic [uts_pkg::NPORTS-1:0] map_en;
	logic [uts_pkg::NPORTS-1:0] rx_match;
	logic [uts_pkg::NPORTS-1:0] tx_match;
	logic rx_hit;
	logic tx_hit;
	logic [PIB-1:0] rx_idx;
	logic [PIB-1:0] tx_idx;
	logic [PIB-1:0] rx_poll_idx_ff;
	logic [PIB-1:0] tx_poll_idx_ff;
	logic rx_enb_q_ff;
	logic tx_enb_q_ff;
	logic rx_sel;
	logic tx_sel;
	uts_pkg::uts_rx_state_e rx_st_ff;
	uts_pkg::uts_tx_state_e tx_st_ff;
	logic [4:0] rx_w_ff;
	logic [4:0] tx_w_ff;
	logic [uts_pkg::DWORD_W-1:0] rx_dword_ff;
	logic [uts_pkg::UWORD_W-1:0] tx_hold_ff;
	logic [uts_pkg::UWORD_W-1:0] rxf_hi;
	logic rx_take;
	logic tx_take;

	////////////////////////////////////////////////////////////////////////////////
	// Bus address to logical port table
	uts_port_map u_map (
		.clk(SYS_CLK),
		.rst_n(RESETN),
		.we(CFG_WE),
		.wr_port(CFG_PORT),
		.wr_phy(CFG_PHY),
		.wr_en(CFG_EN),
		.map_phy(map_phy),
		.map_en(map_en)
	);

	// Per-port address compare for both polling buses
	for (genvar p = 0; p < uts_pkg::NPORTS; p++) begin : g_match // R2 R14
		assign rx_match[p] = map_en[p] && map_phy[p*AW +: AW] == RX_ADDR; // R8
		assign tx_match[p] = map_en[p] && map_phy[p*AW +: AW] == TX_ADDR; // R8
	end

	// Two ports mapped to one address: the highest index answers
	always_comb begin
		rx_hit = |rx_match;
		tx_hit = |tx_match;
		rx_idx = '0;
		tx_idx = '0;
		for (int i = 0; i < uts_pkg::NPORTS; i++) begin
			if (rx_match[i]) begin
				rx_idx = PIB'(i);
			end
			if (tx_match[i]) begin
				tx_idx = PIB'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Polling answers, one cycle after the address
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			RX_CLAV <= 1'b0;
			RX_CLAV_OE <= 1'b0;
			TX_CLAV <= 1'b0;
			TX_CLAV_OE <= 1'b0;
			rx_poll_idx_ff <= '0;
			tx_poll_idx_ff <= '0;
			rx_enb_q_ff <= 1'b1;
			tx_enb_q_ff <= 1'b1;
		end else begin
			RX_CLAV <= rx_hit && RXF_READY[rx_idx]; // R3 R4 R9
			RX_CLAV_OE <= rx_hit; // R16
			TX_CLAV <= tx_hit && TXF_READY[tx_idx]; // R3 R11
			TX_CLAV_OE <= tx_hit; // R16
			rx_poll_idx_ff <= rx_idx;
			tx_poll_idx_ff <= tx_idx;
			rx_enb_q_ff <= RX_ENB_N;
			tx_enb_q_ff <= TX_ENB_N;
		end
	end

	// Select is the falling enable; the address of the cycle before names the port
	assign rx_sel = rx_st_ff == uts_pkg::RX_IDLE && rx_enb_q_ff && !RX_ENB_N
		&& RX_CLAV_OE && RX_CLAV; // R15 R17
	assign tx_sel = tx_st_ff == uts_pkg::TX_IDLE && tx_enb_q_ff && !TX_ENB_N
		&& TX_CLAV_OE && TX_CLAV && TX_SOC; // R15 R17
	assign rx_take = rx_st_ff == uts_pkg::RX_SEND && !RX_ENB_N;
	assign tx_take = tx_st_ff == uts_pkg::TX_RECV && !TX_ENB_N;
	assign rxf_hi = RXF_DATA[31:16];

	////////////////////////////////////////////////////////////////////////////////
	// Receive: one fetch cycle after select, then a word per enabled cycle.
	// The dword that carries word 2 loses its upper half to the dummy HEC.
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_st_ff <= uts_pkg::RX_IDLE;
			rx_w_ff <= uts_pkg::WORD_FIRST;
			rx_dword_ff <= '0;
			RX_DATA <= '0;
			RX_SOC <= 1'b0;
			RX_DATA_OE <= 1'b0;
			RXF_PORT <= '0;
			RXF_RD <= 1'b0;
		end else begin
			RXF_RD <= 1'b0;
			case (rx_st_ff)
				uts_pkg::RX_IDLE: begin
					if (rx_sel) begin
						RXF_PORT <= rx_poll_idx_ff;
						rx_st_ff <= uts_pkg::RX_FETCH;
					end
				end
				uts_pkg::RX_FETCH: begin
					rx_dword_ff <= RXF_DATA; // R1
					RX_DATA <= RXF_DATA[31:16]; // R7
					RXF_RD <= 1'b1;
					RX_SOC <= 1'b1;
					RX_DATA_OE <= 1'b1;
					rx_w_ff <= uts_pkg::WORD_FIRST;
					rx_st_ff <= uts_pkg::RX_SEND;
				end
				uts_pkg::RX_SEND: begin
					if (rx_take) begin
						RX_SOC <= 1'b0;
						if (rx_w_ff == uts_pkg::WORD_LAST) begin // R5 R17
							RX_DATA_OE <= 1'b0;
							rx_st_ff <= uts_pkg::RX_IDLE;
						end else begin
							rx_w_ff <= rx_w_ff + 5'h01;
							if (rx_w_ff[0]) begin
								rx_dword_ff <= RXF_DATA; // R1
								RXF_RD <= 1'b1;
								if (rx_w_ff + 5'h01 == uts_pkg::WORD_HEC) begin
									RX_DATA <= uts_pkg::HEC_DUMMY; // R6
								end else begin
									RX_DATA <= RXF_DATA[31:16]; // R7
								end
							end else begin
								RX_DATA <= rx_dword_ff[15:0];
							end
						end
					end
				end
				default: begin
					RX_DATA_OE <= 1'b0;
					rx_st_ff <= uts_pkg::RX_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit: word 0 arrives with the select edge; odd words complete a dword
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			tx_st_ff <= uts_pkg::TX_IDLE;
			tx_w_ff <= uts_pkg::WORD_FIRST;
			tx_hold_ff <= '0;
			TXF_DATA <= '0;
			TXF_PORT <= '0;
			TXF_WE <= 1'b0;
		end else begin
			TXF_WE <= 1'b0;
			case (tx_st_ff)
				uts_pkg::TX_IDLE: begin
					if (tx_sel) begin
						TXF_PORT <= tx_poll_idx_ff; // R10
						tx_hold_ff <= TX_DATA;
						tx_w_ff <= 5'h01;
						tx_st_ff <= uts_pkg::TX_RECV;
					end
				end
				uts_pkg::TX_RECV: begin
					if (tx_take) begin
						if (tx_w_ff[0]) begin
							TXF_DATA <= {tx_hold_ff, TX_DATA}; // R7 R10
							TXF_WE <= 1'b1; // R12
						end else if (tx_w_ff == uts_pkg::WORD_HEC) begin
							tx_hold_ff <= uts_pkg::HEC_DUMMY; // R13
						end else begin
							tx_hold_ff <= TX_DATA;
						end
						if (tx_w_ff == uts_pkg::WORD_LAST) begin // R13 R17
							tx_st_ff <= uts_pkg::TX_IDLE;
						end else begin
							tx_w_ff <= tx_w_ff + 5'h01;
						end
					end
				end
				default: begin
					tx_st_ff <= uts_pkg::TX_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	sequence s_rx_select;
		rx_sel ##1 (rx_st_ff == uts_pkg::RX_FETCH);
	endsequence

	a_rx_clav_ready: assert property ((rx_hit && RXF_READY[rx_idx]) |=> RX_CLAV && RX_CLAV_OE) // R4
		else $error("receive clav missed a ready port");
	a_clav_release: assert property (!rx_hit && !tx_hit |=> !RX_CLAV_OE && !TX_CLAV_OE) // R16
		else $error("clav driven for a foreign address");
	a_tx_clav_full: assert property ((tx_hit && !TXF_READY[tx_idx]) |=> !TX_CLAV) // R11
		else $error("transmit clav asserted for a full port");
	a_rx_first_word: assert property (s_rx_select |=> RX_SOC && RX_DATA_OE && RXF_RD // R1
		&& RX_DATA == $past(rxf_hi))
		else $error("first receive word not the upper half of the dword");
	a_rx_hec_dummy: assert property (rx_st_ff == uts_pkg::RX_SEND // R6
		&& rx_w_ff == uts_pkg::WORD_HEC |-> RX_DATA == uts_pkg::HEC_DUMMY)
		else $error("receive HEC word not dummy");
	a_rx_cell_end: assert property (rx_take && rx_w_ff == uts_pkg::WORD_LAST // R5
		|=> !RX_DATA_OE ##1 !RX_DATA_OE)
		else $error("receive cell did not end after word 26");
	a_rx_start_clav: assert property (rx_st_ff == uts_pkg::RX_FETCH // R17
		|-> $past(RX_CLAV) && $past(rx_st_ff) == uts_pkg::RX_IDLE)
		else $error("receive cell started without clav");
	a_tx_pack_pair: assert property (tx_take && tx_w_ff[0] |=> TXF_WE // R10
		&& TXF_DATA[15:0] == $past(TX_DATA) && TXF_DATA[31:16] == $past(tx_hold_ff))
		else $error("transmit pair packed wrongly");
	a_tx_hec_mask: assert property (tx_take && tx_w_ff == uts_pkg::WORD_HEC // R13
		|=> tx_hold_ff == uts_pkg::HEC_DUMMY)
		else $error("transmit HEC word not masked");
	a_tx_we_sel: assert property (TXF_WE |-> $past(tx_st_ff) == uts_pkg::TX_RECV) // R12
		else $error("data enable outside a selected cell");
	a_tx_cell_end: assert property (tx_take && tx_w_ff == uts_pkg::WORD_LAST // R13
		|=> tx_st_ff == uts_pkg::TX_IDLE && TXF_WE)
		else $error("transmit cell did not end after word 26");
endmodule : uts_slave_port

// ==== uts_mst.sv ====
module uts_mst (
	// Clock
	input wire logic clk,
	// Receive direction lines
	output logic [4:0] rx_addr,
	output logic rx_enb_n,
	// Transmit direction lines
	output logic [4:0] tx_addr,
	output logic tx_enb_n,
	output logic [15:0] tx_data,
	output logic tx_soc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_addr = 5'h1F;
		tx_addr = 5'h1F;
		rx_enb_n = 1'b1;
		tx_enb_n = 1'b1;
		tx_data = 16'h0000;
		tx_soc = 1'b0;
	end
	// Both directions polled together; returns in the cycle where the answer stands
	task poll(input logic [4:0] a);
		@(negedge clk);
		rx_addr = a;
		tx_addr = a;
		rx_enb_n = 1'b1;
		tx_enb_n = 1'b1;
		@(negedge clk);
	endtask : poll
	task rx_enb(input logic v);
		rx_enb_n = v;
		@(negedge clk);
	endtask : rx_enb
	// While idle the data lines show the inverse so a stale word never matches
	task tx_word(input logic [15:0] d, input logic s, input logic e);
		tx_enb_n = e;
		tx_data = e ? ~d : d;
		tx_soc = s;
		@(negedge clk);
	endtask : tx_word
endmodule : uts_mst

// ==== uts_slave_port_tb.sv ====
module uts_slave_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n;
	logic cfg_we;
	logic [4:0] cfg_port;
	logic [4:0] cfg_phy;
	logic cfg_en;
	logic [31:0] rxf_ready;
	logic [31:0] txf_ready;
	logic [4:0] rx_addr, tx_addr, rxf_port, txf_port;
	logic rx_enb_n, tx_enb_n, tx_soc, rx_clav, rx_clav_oe, rx_soc, rx_data_oe, rxf_rd;
	logic tx_clav, tx_clav_oe, txf_we;
	logic [15:0] tx_data, rx_data;
	logic [31:0] txf_data, rxf_data;
	logic [31:0] dq[$];
	logic [36:0] txq[$];
	logic [4:0] mphy[32];
	logic men[32] = '{default: 1'b0};
	int failures = 0;
	int tests_run = 0;
	int pops = 0;
	always #20 clk = ~clk;
	// Show-ahead FIFO head; when empty a moving pattern, not the last dword
	always @(negedge clk) begin
		if (rxf_rd === 1'b1) begin
			pops++;
			if (dq.size() > 0)
				void'(dq.pop_front());
		end
		if (txf_we === 1'b1)
			txq.push_back({txf_port, txf_data});
		rxf_data = dq.size() > 0 ? dq[0] : ~{rx_data, tx_data};
	end
	uts_slave_port dut (.SYS_CLK(clk), .RESETN(rst_n), .CFG_WE(cfg_we), .CFG_PORT(cfg_port),
		.CFG_PHY(cfg_phy), .CFG_EN(cfg_en), .RX_ADDR(rx_addr), .RX_ENB_N(rx_enb_n),
		.RX_CLAV(rx_clav), .RX_CLAV_OE(rx_clav_oe), .RX_DATA(rx_data), .RX_SOC(rx_soc),
		.RX_DATA_OE(rx_data_oe), .RXF_READY(rxf_ready), .RXF_DATA(rxf_data),
		.RXF_PORT(rxf_port), .RXF_RD(rxf_rd), .TX_ADDR(tx_addr), .TX_ENB_N(tx_enb_n),
		.TX_DATA(tx_data), .TX_SOC(tx_soc), .TX_CLAV(tx_clav), .TX_CLAV_OE(tx_clav_oe),
		.TXF_READY(txf_ready), .TXF_DATA(txf_data), .TXF_PORT(txf_port), .TXF_WE(txf_we));
	uts_mst m (.clk(clk), .rx_addr(rx_addr), .rx_enb_n(rx_enb_n), .tx_addr(tx_addr),
		.tx_enb_n(tx_enb_n), .tx_data(tx_data), .tx_soc(tx_soc));
	task chk(input string n, input logic [36:0] e, input logic [36:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task cfg(input logic [4:0] p, input logic [4:0] a, input logic e);
		cfg_we = 1'b1;
		cfg_port = p;
		cfg_phy = a;
		cfg_en = e;
		@(negedge clk);
		mphy[p] = a;
		men[p] = e;
	endtask : cfg
	// Highest enabled logical port answering to the address, or -1
	function automatic int lookup(input logic [4:0] a);
		int r = -1;
		for (int i = 0; i < 32; i++)
			if (men[i] && mphy[i] == a)
				r = i;
		return r;
	endfunction : lookup
	task final_report;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// Run needs some 155 cycles; the margin covers a stuck handshake
	initial begin
		#200000;
		failures++;
		final_report();
	end
	initial begin
		int p;
		logic [15:0] w[26];
		logic [31:0] dw;
		rst_n = 1'b0;
		cfg_we = 1'b0;
		cfg_port = 5'h00;
		cfg_phy = 5'h00;
		cfg_en = 1'b0;
		rxf_ready = 32'h00000000;
		txf_ready = 32'h00000000;
		void'($urandom(32'h612D));
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk("rx_clav_oe", 1'b0, rx_clav_oe);
		for (int i = 0; i < 10; i++)
			cfg(5'($urandom), 5'($urandom), 1'($urandom));
		cfg(5'h03, 5'h09, 1'b1);
		cfg_we = 1'b0;
		for (int a = 0; a < 32; a++) begin
			rxf_ready = $urandom;
			txf_ready = $urandom;
			m.poll(5'(a));
			p = lookup(5'(a));
			chk("rx_clav_oe", p >= 0, rx_clav_oe);
			chk("rx_clav", p >= 0 && rxf_ready[p], rx_clav);
			chk("tx_clav_oe", p >= 0, tx_clav_oe);
			chk("tx_clav", p >= 0 && txf_ready[p], tx_clav);
		end
		p = lookup(5'h09);
		rxf_ready = 32'h00000000;
		m.poll(5'h09);
		m.rx_enb(1'b0);
		repeat (3) m.rx_enb(1'b1);
		chk("rx_data_oe", 1'b0, rx_data_oe);
		for (int j = 0; j < 13; j++) begin
			dw = $urandom;
			dq.push_back(dw);
			w[2*j] = j == 1 ? 16'h0000 : dw[31:16];
			w[2*j+1] = dw[15:0];
		end
		rxf_ready = 32'h00000001 << p;
		m.poll(5'h09);
		m.rx_enb(1'b0);
		for (int n = 0; n < 8 && rx_data_oe !== 1'b1; n++)
			m.rx_enb(1'b1);
		m.rx_enb(1'b1);
		chk("rxf_port", 5'(p), rxf_port);
		for (int k = 0; k < 26; k++) begin
			if (k == 12)
				m.rx_enb(1'b1);
			chk("rx_data", w[k], rx_data);
			chk("rx_soc", k == 0, rx_soc);
			m.rx_enb(1'b0);
		end
		chk("rx_data_oe", 1'b0, rx_data_oe);
		m.rx_enb(1'b1);
		chk("pops", 37'd13, 37'(pops));
		txf_ready = 32'h00000001 << p;
		m.poll(5'h09);
		// Enable without start of cell must not open a cell
		m.tx_word(16'($urandom), 1'b0, 1'b0);
		m.tx_word(16'h0000, 1'b0, 1'b1);
		for (int k = 0; k < 26; k++) begin
			w[k] = 16'($urandom);
			m.tx_word(w[k], k == 0, 1'b0);
		end
		repeat (3) m.tx_word(16'h0000, 1'b0, 1'b1);
		chk("tx_count", 37'd13, 37'(txq.size()));
		for (int j = 0; j < 13 && j < txq.size(); j++)
			chk("tx_dword", {5'(p), j == 1 ? 16'h0000 : w[2*j], w[2*j+1]}, txq[j]);
		// Reset in mid-run clears the map, so the old address goes quiet
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		men = '{default: 1'b0};
		m.poll(5'h09);
		chk("rx_clav_oe", 1'b0, rx_clav_oe);
		chk("tx_clav_oe", 1'b0, tx_clav_oe);
		final_report();
	end
endmodule : uts_slave_port_tb
